// ---- bench/interval_pwm_timer_assertions.sv ----
`timescale 1ns/10ps
`include "interval_pwm_timer_map.svh"

module interval_pwm_timer_assertions (
  input wire logic                             sys_clk,
  input wire logic                             resetn,
  input wire logic                             clk_en,
  input wire interval_pwm_timer_pkg::mem_req_t mem_req,
  input wire logic [7:0]                       mem_rdata,
  input wire logic                             match_interrupt,
  input wire logic [3:0]                       port2_pin_out,
  input wire logic [3:0]                       port2_pin_oe,
  input wire logic [3:0]                       port2_analog_en
);
  logic [7:0] ctl_reg, ctl_next, per_reg, per_next, duty_reg, duty_next;
  logic [3:0] dir_reg, dir_next, an_reg, an_next;
  logic       lat_reg, lat_next, wr_en, rd_en, pw, stop;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////
  // shadow copies of the written registers
  assign wr_en = clk_en && mem_req.wr;
  assign rd_en = clk_en && mem_req.rd;
  assign pw    = wr_en && (mem_req.addr == `ADDR_PORT2_DIRECTION ||
                           mem_req.addr == `ADDR_PORT2_ANALOG);
  assign stop  = wr_en && mem_req.addr == `ADDR_TIMER_CONTROL && !mem_req.wdata[7];

  always_comb begin
    ctl_next  = ctl_reg;
    per_next  = per_reg;
    duty_next = duty_reg;
    dir_next  = dir_reg;
    an_next   = an_reg;
    lat_next  = lat_reg;
    if (wr_en) begin
      case (mem_req.addr)
        `ADDR_TIMER_CONTROL:   ctl_next = mem_req.wdata;
        `ADDR_PERIOD_COMPARE:  per_next = mem_req.wdata;
        `ADDR_DUTY_COMPARE:    duty_next = mem_req.wdata;
        `ADDR_PORT2_DIRECTION: dir_next = mem_req.wdata[3:0];
        `ADDR_PORT2_ANALOG:    an_next = mem_req.wdata[3:0];
        `ADDR_PORT2_LATCH:     lat_next = mem_req.wdata[0];
        default:               ctl_next = ctl_reg;
      endcase
    end else if (clk_en && mem_req.bit_wr && mem_req.addr == `ADDR_TIMER_CONTROL) begin
      ctl_next[mem_req.bit_sel] = mem_req.wdata[0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_reg  <= 8'h00;
      per_reg  <= 8'h00;
      duty_reg <= 8'h00;
      dir_reg  <= 4'hf;
      an_reg   <= 4'h0;
      lat_reg  <= 1'b0;
    end else begin
      ctl_reg  <= ctl_next;
      per_reg  <= per_next;
      duty_reg <= duty_next;
      dir_reg  <= dir_next;
      an_reg   <= an_next;
      lat_reg  <= lat_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  chk_rdata_holds: assert property (!rd_en |=> $stable(mem_rdata))
    else $error("read data changed without a read");
  chk_period_read: assert property (rd_en && mem_req.addr == `ADDR_PERIOD_COMPARE
    |=> mem_rdata == per_reg) else $error("period compare read mismatch");
  chk_duty_read: assert property (rd_en && mem_req.addr == `ADDR_DUTY_COMPARE
    |=> mem_rdata == duty_reg) else $error("duty compare read mismatch");
  chk_ctrl_read: assert property (rd_en && mem_req.addr == `ADDR_TIMER_CONTROL
    |=> mem_rdata == ctl_reg) else $error("control read mismatch");
  chk_dir_upper_ones: assert property (rd_en && mem_req.addr == `ADDR_PORT2_DIRECTION
    |=> mem_rdata[7:4] == 4'hf) else $error("direction upper bits not ones");
  chk_analog_upper_zero: assert property (rd_en && mem_req.addr == `ADDR_PORT2_ANALOG
    |=> mem_rdata[7:4] == 4'h0) else $error("analog upper bits not zero");
  chk_analog_pins: assert property (wr_en && mem_req.addr == `ADDR_PORT2_ANALOG
    |-> ##2 port2_analog_en == an_reg) else $error("analog enables wrong");
  chk_pin_drive: assert property (!$past(pw) && !$past(pw, 2)
    |-> port2_pin_oe == ~(dir_reg | an_reg)) else $error("pin drive enables wrong");
  chk_irq_needs_run: assert property (!ctl_reg[7] [*4] |-> !match_interrupt)
    else $error("interrupt while stopped");
  chk_stop_level: assert property (stop
    |-> ##3 port2_pin_out[0] == ($past(mem_req.wdata[1], 3) | lat_reg))
    else $error("output not at idle level after stop");

  cover property (match_interrupt);
  cover property (wr_en && mem_req.addr == `ADDR_TIMER_CONTROL && mem_req.wdata == 8'h89);
  cover property (stop ##3 port2_pin_out[0]);
endmodule

// ---- bench/interval_pwm_timer_tb_top.sv ----
`timescale 1ns/10ps
`include "interval_pwm_timer_map.svh"

module interval_pwm_timer_tb_top;
  logic                             sys_clk, resetn, clk_en, low_speed_clk_in;
  logic [3:0]                       port2_pin_in, port2_pin_out, port2_pin_oe, port2_analog_en;
  interval_pwm_timer_pkg::mem_req_t mem_req;
  logic [7:0]                       mem_rdata;
  logic                             match_interrupt;
  int                               fails, tests_run, a, p, n;

  interval_pwm_timer dut (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
    .low_speed_clk_in(low_speed_clk_in), .port2_pin_in(port2_pin_in),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .match_interrupt(match_interrupt),
    .port2_pin_out(port2_pin_out), .port2_pin_oe(port2_pin_oe),
    .port2_analog_en(port2_analog_en)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    low_speed_clk_in = 1'b0;
    #12;
    forever #200 low_speed_clk_in = ~low_speed_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // access and measuring tasks
  task end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task req(input logic [2:0] k, input logic [15:0] ad, input logic [7:0] d,
           input logic [2:0] b);
    @(posedge sys_clk);
    mem_req <= {k, ad, d, b};
    @(posedge sys_clk);
    mem_req <= '0;
  endtask

  task wr(input logic [15:0] ad, input logic [7:0] d);
    req(3'b100, ad, d, 3'h0);
  endtask

  task rd(input string nm, input logic [15:0] ad, input logic [7:0] e);
    req(3'b001, ad, 8'h00, 3'h0);
    @(posedge sys_clk);
    chk(nm, {8'h00, mem_rdata}, {8'h00, e});
  endtask

  task wait_irq(input int lim);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (match_interrupt !== 1'b1 && n < lim);
  endtask

  task width(input logic lev);
    n = 0;
    while (port2_pin_out[0] !== lev && n < 9000) begin @(posedge sys_clk); n++; end
    while (port2_pin_out[0] === lev && n < 9000) begin @(posedge sys_clk); n++; end
    a = 0;
    while (port2_pin_out[0] !== lev && n < 9000) begin @(posedge sys_clk); a++; n++; end
    p = a;
    while (port2_pin_out[0] === lev && n < 9000) begin @(posedge sys_clk); p++; n++; end
  endtask

  task stp;
    wr(`ADDR_TIMER_CONTROL, 8'h00);
    repeat (4) @(posedge sys_clk);
    chk("idle level", {15'h0, port2_pin_out[0]}, 16'h0000);
  endtask

  task gap(input logic [2:0] cs, input int e, input int lim);
    wr(`ADDR_TIMER_CONTROL, {1'b1, cs, 4'h0});
    wait_irq(lim);
    wait_irq(lim);
    chk("tick gap", n[15:0], e[15:0]);
    stp();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    fails = 0;
    tests_run = 0;
    resetn = 1'b0;
    clk_en = 1'b1;
    port2_pin_in = 4'ha;
    mem_req = '0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd("period", `ADDR_PERIOD_COMPARE, 8'h00);
    rd("duty", `ADDR_DUTY_COMPARE, 8'h00);
    rd("control", `ADDR_TIMER_CONTROL, 8'h00);
    rd("direction", `ADDR_PORT2_DIRECTION, 8'hff);
    rd("analog", `ADDR_PORT2_ANALOG, 8'h00);
    rd("pins", `ADDR_PORT2_LATCH, 8'h0a);
    rd("unmapped", 16'hff00, 8'h00);
    $display("test reset_values done");
    wr(`ADDR_PERIOD_COMPARE, 8'h5a);
    rd("period", `ADDR_PERIOD_COMPARE, 8'h5a);
    wr(`ADDR_DUTY_COMPARE, 8'ha5);
    rd("duty", `ADDR_DUTY_COMPARE, 8'ha5);
    req(3'b010, `ADDR_TIMER_CONTROL, 8'h01, 3'h1);
    rd("control bit", `ADDR_TIMER_CONTROL, 8'h02);
    req(3'b010, `ADDR_TIMER_CONTROL, 8'h00, 3'h1);
    rd("control bit", `ADDR_TIMER_CONTROL, 8'h00);
    wr(`ADDR_PORT2_DIRECTION, 8'h3c);
    rd("direction", `ADDR_PORT2_DIRECTION, 8'hfc);
    wr(`ADDR_PORT2_ANALOG, 8'hfa);
    rd("analog", `ADDR_PORT2_ANALOG, 8'h0a);
    chk("analog pins", {12'h0, port2_analog_en}, 16'h000a);
    chk("drive", {12'h0, port2_pin_oe}, 16'h0001);
    wr(`ADDR_PORT2_ANALOG, 8'h00);
    wr(`ADDR_PORT2_DIRECTION, 8'hfe);
    repeat (2) @(posedge sys_clk);
    chk("drive", {12'h0, port2_pin_oe}, 16'h0001);
    wr(`ADDR_PORT2_LATCH, 8'h0e);
    @(posedge sys_clk);
    chk("latch pins", {12'h0, port2_pin_out}, 16'h000e);
    $display("test register_access done");
    wr(`ADDR_PERIOD_COMPARE, 8'h03);
    wr(`ADDR_DUTY_COMPARE, 8'h01);
    wr(`ADDR_TIMER_CONTROL, 8'h81);
    width(1'b0);
    chk("square high", a[15:0], 16'h0004);
    chk("square period", p[15:0], 16'h0008);
    wait_irq(100);
    wait_irq(100);
    chk("interval gap", n[15:0], 16'h0004);
    clk_en <= 1'b0;
    repeat (10) @(posedge sys_clk);
    clk_en <= 1'b1;
    wait_irq(100);
    chk("frozen gap", n[15:0], 16'h0004);
    stp();
    $display("test interval done");
    wr(`ADDR_PERIOD_COMPARE, 8'h00);
    gap(3'h0, 1, 100);
    gap(3'h1, 4, 100);
    gap(3'h2, 16, 100);
    gap(3'h3, 64, 200);
    gap(3'h4, 4096, 5000);
    gap(3'h5, 1024, 2000);
    gap(3'h6, 300, 300);
    gap(3'h7, 300, 300);
    $display("test clock_select done");
    wr(`ADDR_PERIOD_COMPARE, 8'h07);
    wr(`ADDR_DUTY_COMPARE, 8'h02);
    wr(`ADDR_TIMER_CONTROL, 8'h89);
    a = 0;
    repeat (10) begin
      @(posedge sys_clk);
      if (port2_pin_out[0] !== 1'b0) a++;
    end
    chk("masked start", a[15:0], 16'h0000);
    width(1'b0);
    chk("pwm active", a[15:0], 16'h0003);
    chk("pwm period", p[15:0], 16'h0008);
    wait_irq(100);
    wait_irq(100);
    chk("pwm irq gap", n[15:0], 16'h0008);
    wr(`ADDR_DUTY_COMPARE, 8'h04);
    repeat (30) @(posedge sys_clk);
    width(1'b0);
    chk("new duty", a[15:0], 16'h0005);
    stp();
    wr(`ADDR_DUTY_COMPARE, 8'h02);
    wr(`ADDR_TIMER_CONTROL, 8'h0b);
    repeat (3) @(posedge sys_clk);
    chk("idle high", {15'h0, port2_pin_out[0]}, 16'h0001);
    wr(`ADDR_TIMER_CONTROL, 8'h8b);
    width(1'b1);
    chk("inverted active", a[15:0], 16'h0003);
    stp();
    $display("test pwm done");
    wr(`ADDR_DUTY_COMPARE, 8'h02);
    wr(`ADDR_TIMER_CONTROL, 8'h89);
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("reset pin", {15'h0, port2_pin_out[0]}, 16'h0000);
    rd("period", `ADDR_PERIOD_COMPARE, 8'h00);
    rd("duty", `ADDR_DUTY_COMPARE, 8'h00);
    rd("control", `ADDR_TIMER_CONTROL, 8'h00);
    rd("direction", `ADDR_PORT2_DIRECTION, 8'hff);
    $display("test mid_reset done");
    end_of_test();
  end

  initial begin
    #2_000_000;
    fails++;
    end_of_test();
  end
endmodule

bind interval_pwm_timer interval_pwm_timer_assertions u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .mem_req(mem_req),
  .mem_rdata(mem_rdata), .match_interrupt(match_interrupt),
  .port2_pin_out(port2_pin_out), .port2_pin_oe(port2_pin_oe),
  .port2_analog_en(port2_analog_en)
);

// ---- src/count_tick_gen.sv ----
`timescale 1ns/10ps
`include "interval_pwm_timer_map.svh"

module count_tick_gen #(
  parameter int PRESCALE_BITS = `PRESCALE_BITS,
  parameter int LS_BITS       = `LOW_SPEED_DIV_BITS
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       run,
  input  wire logic [2:0] clock_select,
  input  wire logic       low_speed_clk_in,
  output logic            tick
);

  logic [PRESCALE_BITS-1:0] presc_reg;
  logic [PRESCALE_BITS-1:0] presc_next;
  logic [LS_BITS-1:0]       ls_cnt_reg;
  logic [LS_BITS-1:0]       ls_cnt_next;
  logic [2:0]               ls_sync_reg;
  logic                     tick_reg;
  logic                     tick_next;
  logic                     ls_edge;

  ////////////////////////////////////////////////////////////////////////////
  // dividers and tap select
  always_comb begin
    ls_edge     = ls_sync_reg[1] & ~ls_sync_reg[2];
    presc_next  = run ? PRESCALE_BITS'(presc_reg + 1'b1) : '0;
    ls_cnt_next = ls_cnt_reg;
    if (!run) begin
      ls_cnt_next = '0;
    end else if (ls_edge) begin
      ls_cnt_next = LS_BITS'(ls_cnt_reg + 1'b1);
    end
    unique case (clock_select)
      `SEL_DIV1:             tick_next = run;
      `SEL_DIV4:             tick_next = run & (&presc_reg[1:0]);
      `SEL_DIV16:            tick_next = run & (&presc_reg[3:0]);
      `SEL_DIV64:            tick_next = run & (&presc_reg[5:0]);
      `SEL_DIV4096:          tick_next = run & (&presc_reg[11:0]);
      `SEL_LOW_SPEED_DIV128: tick_next = run & ls_edge & (&ls_cnt_reg);
      default:               tick_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_reg   <= '0;
      ls_cnt_reg  <= '0;
      ls_sync_reg <= 3'h0;
      tick_reg    <= 1'b0;
    end else if (clk_en) begin
      presc_reg   <= presc_next;
      ls_cnt_reg  <= ls_cnt_next;
      ls_sync_reg <= {ls_sync_reg[1:0], low_speed_clk_in};
      tick_reg    <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule

// ---- src/interval_pwm_timer.sv ----
`timescale 1ns/10ps
`include "interval_pwm_timer_map.svh"

module interval_pwm_timer (
  input  wire logic                             sys_clk,
  input  wire logic                             resetn,
  input  wire logic                             clk_en,
  input  wire logic                             low_speed_clk_in,
  input  wire logic [3:0]                       port2_pin_in,
  input  wire interval_pwm_timer_pkg::mem_req_t mem_req,
  output logic      [7:0]                       mem_rdata,
  output logic                                  match_interrupt,
  output logic      [3:0]                       port2_pin_out,
  output logic      [3:0]                       port2_pin_oe,
  output logic      [3:0]                       port2_analog_en
);

  logic [1:0]                           rst_sync_reg;
  logic                                 rst_n;
  logic [3:0]                           pin_sync_reg;
  interval_pwm_timer_pkg::timer_ctrl_t  ctrl_reg;
  interval_pwm_timer_pkg::timer_ctrl_t  ctrl_next;
  logic [7:0]                           period_reg;
  logic [7:0]                           period_next;
  logic [7:0]                           duty_wr_reg;
  logic [7:0]                           duty_wr_next;
  logic [7:0]                           duty_act_reg;
  logic [7:0]                           duty_act_next;
  logic                                 pend_reg;
  logic                                 pend_next;
  logic [1:0]                           guard_reg;
  logic [1:0]                           guard_next;
  logic [7:0]                           dir_reg;
  logic [7:0]                           dir_next;
  logic [7:0]                           analog_reg;
  logic [7:0]                           analog_next;
  logic [7:0]                           latch_reg;
  logic [7:0]                           latch_next;
  logic [7:0]                           count_reg;
  logic [7:0]                           count_next;
  interval_pwm_timer_pkg::compare_phase_t phase_reg;
  interval_pwm_timer_pkg::compare_phase_t phase_next;
  logic                                 mask_reg;
  logic                                 mask_next;
  logic                                 tout_reg;
  logic                                 tout_next;
  logic                                 irq_reg;
  logic                                 irq_next;
  logic [7:0]                           rdata_reg;
  logic [7:0]                           rdata_next;
  logic [3:0]                           pin_out_reg;
  logic [3:0]                           pin_oe_reg;
  logic                                 tick;
  logic                                 is_pwm;
  logic                                 any_wr;
  logic [7:0]                           wr_val;
  logic [7:0]                           cur_val;
  logic                                 duty_wr;
  logic                                 pmatch;
  logic                                 dmatch;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      logic [1:0] sync_reg;
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync_reg <= 2'h0;
        end else if (clk_en) begin
          sync_reg <= {sync_reg[0], port2_pin_in[gi]};
        end
      end
      assign pin_sync_reg[gi] = sync_reg[1];
    end
  endgenerate

  count_tick_gen u_tick (
    .clk              (sys_clk),
    .rst_n            (rst_n),
    .clk_en           (clk_en),
    .run              (ctrl_reg.run_enable),
    .clock_select     (ctrl_reg.clock_select),
    .low_speed_clk_in (low_speed_clk_in),
    .tick             (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register access
  always_comb begin
    any_wr = mem_req.wr | mem_req.bit_wr;
    unique case (mem_req.addr)
      `ADDR_TIMER_CONTROL:   cur_val = ctrl_reg;
      `ADDR_PERIOD_COMPARE:  cur_val = period_reg;
      `ADDR_DUTY_COMPARE:    cur_val = duty_wr_reg;
      `ADDR_PORT2_DIRECTION: cur_val = dir_reg;
      `ADDR_PORT2_ANALOG:    cur_val = analog_reg;
      `ADDR_PORT2_LATCH:     cur_val = latch_reg;
      default:               cur_val = `UNMAPPED_READ;
    endcase
    wr_val = mem_req.wdata;
    if (mem_req.bit_wr) begin
      wr_val = cur_val;
      wr_val[mem_req.bit_sel] = mem_req.wdata[0];
    end
    ctrl_next   = ctrl_reg;
    period_next = period_reg;
    duty_wr     = 1'b0;
    dir_next    = dir_reg;
    analog_next = analog_reg;
    latch_next  = latch_reg;
    if (any_wr) begin
      unique case (mem_req.addr)
        `ADDR_TIMER_CONTROL:   ctrl_next = wr_val;
        `ADDR_PERIOD_COMPARE:  period_next = wr_val;
        `ADDR_DUTY_COMPARE:    duty_wr = mem_req.wr;
        `ADDR_PORT2_DIRECTION: dir_next = wr_val | `PORT2_DIR_FIXED_ONES;
        `ADDR_PORT2_ANALOG:    analog_next = wr_val & `PORT2_LOW_MASK;
        `ADDR_PORT2_LATCH:     latch_next = wr_val & `PORT2_LOW_MASK;
        default:               ;
      endcase
    end
    rdata_next = rdata_reg;
    if (mem_req.rd) begin
      rdata_next = cur_val;
      if (mem_req.addr == `ADDR_PORT2_LATCH) begin
        rdata_next = {4'h0, (dir_reg[3:0] & pin_sync_reg) | (~dir_reg[3:0] & latch_reg[3:0])};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter, compare and output
  always_comb begin
    is_pwm        = ctrl_reg.mode_select[1];
    pmatch        = (phase_reg == interval_pwm_timer_pkg::CMP_PERIOD) && (count_reg == period_reg);
    dmatch        = is_pwm && (phase_reg == interval_pwm_timer_pkg::CMP_DUTY) &&
                    (count_reg == duty_act_reg);
    count_next    = count_reg;
    phase_next    = phase_reg;
    mask_next     = mask_reg;
    tout_next     = tout_reg;
    irq_next      = 1'b0;
    duty_wr_next  = duty_wr ? wr_val : duty_wr_reg;
    duty_act_next = duty_act_reg;
    pend_next     = pend_reg | duty_wr;
    guard_next    = guard_reg;
    if (duty_wr) begin
      guard_next = 2'h0;
    end else if (tick && guard_reg != `DUTY_GUARD_TICKS) begin
      guard_next = 2'(guard_reg + 1'b1);
    end
    if (!ctrl_reg.run_enable) begin
      count_next    = 8'h00;
      phase_next    = interval_pwm_timer_pkg::CMP_PERIOD;
      mask_next     = 1'b1;
      tout_next     = ctrl_reg.output_default_level;
      duty_act_next = duty_wr_next;
      pend_next     = 1'b0;
    end else if (tick) begin
      if (is_pwm && mask_reg) begin
        mask_next = 1'b0;
      end else if (pmatch) begin
        count_next = 8'h00;
        irq_next   = 1'b1;
        if (is_pwm) begin
          phase_next = interval_pwm_timer_pkg::CMP_DUTY;
          tout_next  = ctrl_reg.output_default_level ^ ctrl_reg.output_drive_enable;
        end else if (ctrl_reg.output_drive_enable) begin
          tout_next = ~tout_reg;
        end
      end else begin
        count_next = 8'(count_reg + 1'b1);
        if (dmatch) begin
          phase_next = interval_pwm_timer_pkg::CMP_PERIOD;
          tout_next  = ctrl_reg.output_default_level;
          if (pend_reg && !duty_wr && guard_reg == `DUTY_GUARD_TICKS) begin
            duty_act_next = duty_wr_reg;
            pend_next     = 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg     <= `RST_TIMER_CONTROL;
      period_reg   <= `RST_COMPARE;
      duty_wr_reg  <= `RST_COMPARE;
      duty_act_reg <= `RST_COMPARE;
      pend_reg     <= 1'b0;
      guard_reg    <= 2'h0;
      dir_reg      <= `RST_PORT2_DIRECTION;
      analog_reg   <= `RST_PORT2_ANALOG;
      latch_reg    <= `RST_PORT2_LATCH;
      count_reg    <= 8'h00;
      phase_reg    <= interval_pwm_timer_pkg::CMP_PERIOD;
      mask_reg     <= 1'b1;
      tout_reg     <= 1'b0;
      irq_reg      <= 1'b0;
      rdata_reg    <= 8'h00;
      pin_out_reg  <= 4'h0;
      pin_oe_reg   <= 4'h0;
    end else if (clk_en) begin
      ctrl_reg     <= ctrl_next;
      period_reg   <= period_next;
      duty_wr_reg  <= duty_wr_next;
      duty_act_reg <= duty_act_next;
      pend_reg     <= pend_next;
      guard_reg    <= guard_next;
      dir_reg      <= dir_next;
      analog_reg   <= analog_next;
      latch_reg    <= latch_next;
      count_reg    <= count_next;
      phase_reg    <= phase_next;
      mask_reg     <= mask_next;
      tout_reg     <= tout_next;
      irq_reg      <= irq_next;
      rdata_reg    <= rdata_next;
      pin_out_reg  <= {latch_next[3:1], latch_next[0] | tout_next};
      pin_oe_reg   <= ~dir_next[3:0] & ~analog_next[3:0];
    end
  end

  assign mem_rdata       = rdata_reg;
  assign match_interrupt = irq_reg;
  assign port2_pin_out   = pin_out_reg;
  assign port2_pin_oe    = pin_oe_reg;
  assign port2_analog_en = analog_reg[3:0];

endmodule

// ---- src/interval_pwm_timer_map.svh ----
`ifndef INTERVAL_PWM_TIMER_MAP_SVH
`define INTERVAL_PWM_TIMER_MAP_SVH

// byte addresses
`define ADDR_DUTY_COMPARE    16'hFF0F
`define ADDR_PERIOD_COMPARE  16'hFF0E
`define ADDR_PORT2_LATCH     16'hFF02
`define ADDR_PORT2_DIRECTION 16'hFF22
`define ADDR_TIMER_CONTROL   16'hFF70
`define ADDR_PORT2_ANALOG    16'hFF84

// reset values
`define RST_COMPARE          8'h00
`define RST_TIMER_CONTROL    8'h00
`define RST_PORT2_DIRECTION  8'hFF
`define RST_PORT2_ANALOG     8'h00
`define RST_PORT2_LATCH      8'h00

// fixed bits of the port registers and the unmapped read value
`define PORT2_DIR_FIXED_ONES 8'hF0
`define PORT2_LOW_MASK       8'h0F
`define UNMAPPED_READ        8'h00

// clock-select codes
`define SEL_DIV1             3'h0
`define SEL_DIV4             3'h1
`define SEL_DIV16            3'h2
`define SEL_DIV64            3'h3
`define SEL_DIV4096          3'h4
`define SEL_LOW_SPEED_DIV128 3'h5

// divider widths, log2 of the ratios
`define PRESCALE_BITS        12
`define LOW_SPEED_DIV_BITS   7

// count clocks that must pass between a duty write and its transfer while the timer runs
`define DUTY_GUARD_TICKS     2'h3

`endif

// ---- src/interval_pwm_timer_pkg.sv ----
package interval_pwm_timer_pkg;

  typedef enum logic [1:0] {
    MODE_INTERVAL = 2'b00,
    MODE_PWM      = 2'b10
  } timer_mode_t;

  typedef enum logic [1:0] {
    CMP_PERIOD = 2'b01,
    CMP_DUTY   = 2'b10
  } compare_phase_t;

  typedef struct packed {
    logic       run_enable;
    logic [2:0] clock_select;
    logic [1:0] mode_select;
    logic       output_default_level;
    logic       output_drive_enable;
  } timer_ctrl_t;

  typedef struct packed {
    logic        wr;
    logic        bit_wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [2:0]  bit_sel;
  } mem_req_t;

endpackage
